// [design/cldw_pkg.sv]
package cldw_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_WAKE_EN     = 8'h01;
  localparam logic [7:0] ADDR_ACT_STATUS  = 8'h1C;
  localparam logic [7:0] ADDR_LOAD_CTRL   = 8'h20;
  localparam logic [7:0] ADDR_DET_FLAGS   = 8'h27;
  localparam logic [7:0] ADDR_REG_TRIM    = 8'h56;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_CHG_STB_EN   = 7;
  localparam int BIT_LOAD_STB_EN  = 8;
  localparam int BIT_CHG_SLP_EN   = 9;
  localparam int BIT_LOAD_SLP_EN  = 10;
  localparam int BIT_ACTIVE       = 0;
  localparam int BIT_SHORT_SEL    = 0;
  localparam int BIT_LOAD_PWR_ON  = 3;
  localparam int BIT_CHG_LOW_F    = 8;
  localparam int BIT_CHG_HIGH_F   = 9;
  localparam int BIT_LOAD_LOW_F   = 10;
  localparam int BIT_LOAD_HIGH_F  = 11;
  localparam int BIT_CHG_LIVE     = 14;
  localparam int BIT_LOAD_LIVE    = 15;
  localparam int COMP_LSB         = 1;
  localparam int COMP_MSB         = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_WAKE_EN   = 16'h0000;
  localparam logic [15:0] RST_LOAD_CTRL = 16'h0000;
  localparam logic [2:0]  RST_COMP_CODE = 3'h0;
  localparam logic [2:0]  COMP_ALIAS    = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STARTUP_MS      = 5;
  localparam int WAKE_MS         = 2;
  localparam int LOAD_QUAL_US    = 20;
  localparam int STARTUP_CYCLES  = STARTUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES     = WAKE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOAD_CYCLES     = LOAD_QUAL_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W           = 20;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CLDW_SHUTDOWN = 2'b00,
    CLDW_ACTIVE   = 2'b01,
    CLDW_STANDBY  = 2'b10,
    CLDW_SLEEP    = 2'b11
  } cldw_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cldw_req_t;

  typedef struct packed {
    logic charger_high;
    logic charger_low;
    logic load_low;
    logic load_high;
  } cldw_events_t;

endpackage

// [design/cldw_sync.sv]
`timescale 1ns/10ps
module cldw_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [design/cldw_qual.sv]
`timescale 1ns/10ps
module cldw_qual (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // Qualification
  input  wire logic                        level_in,
  input  wire logic [cldw_pkg::CNT_W-1:0]  target,
  output logic                             qualified
);

  logic [cldw_pkg::CNT_W-1:0] count;

  // Restart on any drop before the width elapses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count     <= '0;
      qualified <= 1'b0;
    end else if (!level_in) begin
      count     <= '0;
      qualified <= 1'b0;
    end else if (count + 1'b1 >= target) begin
      qualified <= 1'b1;
    end else begin
      // A raised target drops the flag until the longer width is met
      count     <= count + 1'b1;
      qualified <= 1'b0;
    end
  end

endmodule

// [design/cldw_top.sv]
`timescale 1ns/10ps
// Overview of operation
// - Shutdown to Active needs charger sense high continuously for 5 ms.
// - Register 0x1C bit 0 reads one once startup reaches Active.
// - Charger sense high 2 ms wakes Sleep or Standby when enabled.
// - Register 0x01 bit 7 enables Standby, bit 9 Sleep charger wake.
// - Charger rising above upper threshold is plug-in event, interrupt.
// - Charger falling below low threshold is plug-out event, interrupt.
// - 0x27 bit 14 live charger, bits 9 and 8 latched high/low.
// - Short-current load pull-down with FETs off reports heavy load.
// - 0x27 bit 15 live load, bits 11 and 10 latched low/high.
// - Register 0x01 bit 8 enables Standby, bit 10 Sleep load wake.
// - Normal-current load pull-down with FETs off flags load detected.
// - Load sense rising above release level flags load released.
// - Compensation code lives in 0x56 bits 3:1, reset 000.
// - Code 111 applies the same compensation as code 000.
// - 0x20 bit 0 selects normal or larger short-detect current.
module cldw_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Comparators
  input  wire logic                  charger_sense_high,
  input  wire logic                  charger_sense_low,
  input  wire logic                  load_sense_low,
  input  wire logic                  load_sense_high,
  input  wire logic                  fets_off,
  // Power management
  input  wire logic                  sleep_req,
  input  wire logic                  standby_req,
  input  wire logic                  shutdown_req,
  // Register port
  input  wire cldw_pkg::cldw_req_t   reg_req,
  output logic [15:0]                reg_rdata,
  // Outputs
  output logic                       active_state_bit,
  output logic                       interrupt_output_pin,
  output logic                       load_detect_power_on,
  output logic                       short_detect_current_sel,
  output logic [2:0]                 supply_comp_code,
  output logic [1:0]                 power_state
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [3:0] raw_in;
  logic [3:0] syn_in;
  logic       fets_off_s;
  logic       chg_hi_s;
  logic       chg_lo_s;
  logic       ld_lo_s;
  logic       ld_hi_s;

  assign raw_in = {charger_sense_high, charger_sense_low,
                   load_sense_low, load_sense_high};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      cldw_sync u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (raw_in[gi]),
        .sync_out (syn_in[gi])
      );
    end
  endgenerate

  cldw_sync u_sync_fet (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (fets_off),
    .sync_out (fets_off_s)
  );

  assign chg_hi_s = syn_in[3];
  assign chg_lo_s = syn_in[2];
  assign ld_lo_s  = syn_in[1];
  assign ld_hi_s  = syn_in[0];

  // ****************************************************************
  // Pulse-width qualification
  // ****************************************************************
  localparam logic [cldw_pkg::CNT_W-1:0] START_T =
    cldw_pkg::CNT_W'(cldw_pkg::STARTUP_CYCLES);
  localparam logic [cldw_pkg::CNT_W-1:0] WAKE_T =
    cldw_pkg::CNT_W'(cldw_pkg::WAKE_CYCLES);
  localparam logic [cldw_pkg::CNT_W-1:0] LOAD_T =
    cldw_pkg::CNT_W'(cldw_pkg::LOAD_CYCLES);

  cldw_pkg::cldw_state_t state;
  cldw_pkg::cldw_state_t next_state;
  logic                  chg_q;
  logic                  chg_lo_q;
  logic                  ld_lo_q;
  logic                  ld_hi_q;
  logic                  ld_armed;
  logic [cldw_pkg::CNT_W-1:0] chg_target;

  // Shutdown needs the longer startup width, re-armed on entry
  assign chg_target = (next_state == cldw_pkg::CLDW_SHUTDOWN) ? START_T
                                                              : WAKE_T;

  cldw_qual u_q_chg (
    .clk       (clk),
    .reset_n   (reset_n),
    .level_in  (chg_hi_s),
    .target    (chg_target),
    .qualified (chg_q)
  );

  cldw_qual u_q_chg_lo (
    .clk       (clk),
    .reset_n   (reset_n),
    .level_in  (chg_lo_s),
    .target    (LOAD_T),
    .qualified (chg_lo_q)
  );

  cldw_qual u_q_ld_lo (
    .clk       (clk),
    .reset_n   (reset_n),
    .level_in  (ld_lo_s && ld_armed),
    .target    (LOAD_T),
    .qualified (ld_lo_q)
  );

  cldw_qual u_q_ld_hi (
    .clk       (clk),
    .reset_n   (reset_n),
    .level_in  (ld_hi_s && ld_armed),
    .target    (LOAD_T),
    .qualified (ld_hi_q)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] wake_en;
  logic [15:0] load_ctrl;
  logic [15:0] trim;
  logic        wr_wake;
  logic        wr_load;
  logic        wr_trim;
  logic        wr_flags;

  assign wr_wake  = reg_req.wr && reg_req.addr == cldw_pkg::ADDR_WAKE_EN;
  assign wr_load  = reg_req.wr && reg_req.addr == cldw_pkg::ADDR_LOAD_CTRL;
  assign wr_trim  = reg_req.wr && reg_req.addr == cldw_pkg::ADDR_REG_TRIM;
  assign wr_flags = reg_req.wr && reg_req.addr == cldw_pkg::ADDR_DET_FLAGS;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_en <= cldw_pkg::RST_WAKE_EN;
    end else if (wr_wake) begin
      wake_en <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      load_ctrl <= cldw_pkg::RST_LOAD_CTRL;
    end else if (wr_load) begin
      // Power-on accepted only when Active with FETs off
      load_ctrl[cldw_pkg::BIT_SHORT_SEL] <=
        reg_req.wdata[cldw_pkg::BIT_SHORT_SEL];
      if (state == cldw_pkg::CLDW_ACTIVE && fets_off_s) begin
        load_ctrl[cldw_pkg::BIT_LOAD_PWR_ON] <=
          reg_req.wdata[cldw_pkg::BIT_LOAD_PWR_ON];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trim <= '0;
    end else if (wr_trim) begin
      trim <= reg_req.wdata;
    end
  end

  // Load comparators only trusted with the function powered, FETs off
  assign ld_armed = load_ctrl[cldw_pkg::BIT_LOAD_PWR_ON] && fets_off_s;

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  logic chg_wake;
  logic ld_wake;

  assign chg_wake = chg_q &&
    ((state == cldw_pkg::CLDW_STANDBY &&
      wake_en[cldw_pkg::BIT_CHG_STB_EN]) ||
     (state == cldw_pkg::CLDW_SLEEP &&
      wake_en[cldw_pkg::BIT_CHG_SLP_EN]));
  assign ld_wake = ld_lo_q &&
    ((state == cldw_pkg::CLDW_STANDBY &&
      wake_en[cldw_pkg::BIT_LOAD_STB_EN]) ||
     (state == cldw_pkg::CLDW_SLEEP &&
      wake_en[cldw_pkg::BIT_LOAD_SLP_EN]));

  always_comb begin
    next_state = state;
    unique case (state)
      cldw_pkg::CLDW_SHUTDOWN: begin
        if (chg_q) begin
          next_state = cldw_pkg::CLDW_ACTIVE;
        end
      end
      cldw_pkg::CLDW_ACTIVE: begin
        if (shutdown_req) begin
          next_state = cldw_pkg::CLDW_SHUTDOWN;
        end else if (sleep_req) begin
          next_state = cldw_pkg::CLDW_SLEEP;
        end else if (standby_req) begin
          next_state = cldw_pkg::CLDW_STANDBY;
        end
      end
      cldw_pkg::CLDW_STANDBY,
      cldw_pkg::CLDW_SLEEP: begin
        if (chg_wake || ld_wake) begin
          next_state = cldw_pkg::CLDW_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= cldw_pkg::CLDW_SHUTDOWN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Detect flags
  // ****************************************************************
  logic                   chg_live;
  logic                   ld_live;
  logic                   chg_q_d;
  logic                   chg_lo_q_d;
  logic                   ld_lo_q_d;
  logic                   ld_hi_q_d;
  cldw_pkg::cldw_events_t ev;
  cldw_pkg::cldw_events_t latched;
  cldw_pkg::cldw_events_t clr;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chg_q_d    <= 1'b0;
      chg_lo_q_d <= 1'b0;
      ld_lo_q_d  <= 1'b0;
      ld_hi_q_d  <= 1'b0;
    end else begin
      chg_q_d    <= chg_q;
      chg_lo_q_d <= chg_lo_q;
      ld_lo_q_d  <= ld_lo_q;
      ld_hi_q_d  <= ld_hi_q;
    end
  end

  assign ev.charger_high = chg_q && !chg_q_d;
  assign ev.charger_low  = chg_lo_q && !chg_lo_q_d;
  assign ev.load_low     = ld_lo_q && !ld_lo_q_d;
  assign ev.load_high    = ld_hi_q && !ld_hi_q_d;

  // Write one to clear
  assign clr.charger_high = wr_flags &&
    reg_req.wdata[cldw_pkg::BIT_CHG_HIGH_F];
  assign clr.charger_low  = wr_flags &&
    reg_req.wdata[cldw_pkg::BIT_CHG_LOW_F];
  assign clr.load_low     = wr_flags &&
    reg_req.wdata[cldw_pkg::BIT_LOAD_HIGH_F];
  assign clr.load_high    = wr_flags &&
    reg_req.wdata[cldw_pkg::BIT_LOAD_LOW_F];

  // Set wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latched <= '0;
    end else begin
      latched <= ev | (latched & ~clr);
    end
  end

  // Live status follows the last qualified edge; load live also clears while disarmed
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chg_live <= 1'b0;
      ld_live  <= 1'b0;
    end else begin
      if (ev.charger_high) begin
        chg_live <= 1'b1;
      end else if (ev.charger_low) begin
        chg_live <= 1'b0;
      end
      if (!ld_armed || ev.load_high) begin
        ld_live <= 1'b0;
      end else if (ev.load_low) begin
        ld_live <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Outputs and read data
  // ****************************************************************
  logic [15:0] flags_word;
  logic [2:0]  code;

  assign code = trim[cldw_pkg::COMP_MSB:cldw_pkg::COMP_LSB];

  always_comb begin
    flags_word = '0;
    flags_word[cldw_pkg::BIT_CHG_LIVE]    = chg_live;
    flags_word[cldw_pkg::BIT_LOAD_LIVE]   = ld_live;
    flags_word[cldw_pkg::BIT_CHG_HIGH_F]  = latched.charger_high;
    flags_word[cldw_pkg::BIT_CHG_LOW_F]   = latched.charger_low;
    flags_word[cldw_pkg::BIT_LOAD_HIGH_F] = latched.load_low;
    flags_word[cldw_pkg::BIT_LOAD_LOW_F]  = latched.load_high;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        cldw_pkg::ADDR_WAKE_EN:    reg_rdata <= wake_en;
        cldw_pkg::ADDR_ACT_STATUS: reg_rdata <=
          {15'h0000, state == cldw_pkg::CLDW_ACTIVE};
        cldw_pkg::ADDR_LOAD_CTRL:  reg_rdata <= load_ctrl;
        cldw_pkg::ADDR_DET_FLAGS:  reg_rdata <= flags_word;
        cldw_pkg::ADDR_REG_TRIM:   reg_rdata <= trim;
        default:                   reg_rdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_state_bit         <= 1'b0;
      interrupt_output_pin     <= 1'b0;
      load_detect_power_on     <= 1'b0;
      short_detect_current_sel <= 1'b0;
      supply_comp_code         <= cldw_pkg::RST_COMP_CODE;
      power_state              <= 2'b00;
    end else begin
      active_state_bit <= (next_state == cldw_pkg::CLDW_ACTIVE);
      interrupt_output_pin <= |latched;
      load_detect_power_on <= load_ctrl[cldw_pkg::BIT_LOAD_PWR_ON];
      short_detect_current_sel <=
        load_ctrl[cldw_pkg::BIT_SHORT_SEL];
      supply_comp_code <= (code == cldw_pkg::COMP_ALIAS) ?
        cldw_pkg::RST_COMP_CODE : code;
      power_state <= next_state;
    end
  end

endmodule

// [dv/cldw_top_assertions.sv]
`timescale 1ns/10ps
module cldw_top_assertions (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset_n,
  // Watched inputs
  input wire logic                charger_sense_high,
  input wire logic                load_sense_low,
  input wire cldw_pkg::cldw_req_t reg_req,
  // Watched outputs
  input wire logic [15:0]         reg_rdata,
  input wire logic                active_state_bit,
  input wire logic                load_detect_power_on,
  input wire logic                short_detect_current_sel,
  input wire logic [2:0]          supply_comp_code,
  input wire logic [1:0]          power_state
);
  // ********
  // Helpers
  // ********
  logic [19:0] chg_run;
  logic [19:0] ld_run;
  logic [15:0] wake_en;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Raw run lengths; the design may only act after at least this long
  always_ff @(posedge clk) begin
    if (!reset_n || !charger_sense_high) chg_run <= 20'h00000;
    else if (~&chg_run) chg_run <= chg_run + 20'h00001;
  end
  always_ff @(posedge clk) begin
    if (!reset_n || !load_sense_low) ld_run <= 20'h00000;
    else if (~&ld_run) ld_run <= ld_run + 20'h00001;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) wake_en <= 16'h0000;
    else if (reg_req.wr && reg_req.addr == 8'h01) wake_en <= reg_req.wdata;
  end

  // ********
  // Checks
  // ********
  a_active_bit: assert property (
    active_state_bit == (power_state == 2'h1))
    else $error("active bit disagrees with power state");
  a_startup_width: assert property (
    power_state == 2'h1 && $past(power_state) == 2'h0
    |-> chg_run >= cldw_pkg::STARTUP_CYCLES)
    else $error("startup taken on a short charger pulse");
  a_standby_wake: assert property (
    power_state == 2'h1 && $past(power_state) == 2'h2
    |-> (wake_en[7] && chg_run >= cldw_pkg::WAKE_CYCLES)
     || (wake_en[8] && ld_run >= cldw_pkg::LOAD_CYCLES))
    else $error("standby wake without enabled qualified cause");
  a_sleep_wake: assert property (
    power_state == 2'h1 && $past(power_state) == 2'h3
    |-> (wake_en[9] && chg_run >= cldw_pkg::WAKE_CYCLES)
     || (wake_en[10] && ld_run >= cldw_pkg::LOAD_CYCLES))
    else $error("sleep wake without enabled qualified cause");
  a_status_read: assert property (
    reg_req.rd && reg_req.addr == 8'h1C
    |=> reg_rdata == {15'h0000, $past(active_state_bit)})
    else $error("status read differs from active bit");
  a_unmapped_read: assert property (
    reg_req.rd && !(reg_req.addr inside {8'h01, 8'h1C, 8'h20, 8'h27, 8'h56})
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_comp_code: assert property (
    reg_req.wr && reg_req.addr == 8'h56
    |-> ##2 supply_comp_code == (($past(reg_req.wdata[3:1], 2) == 3'h7)
        ? 3'h0 : $past(reg_req.wdata[3:1], 2)))
    else $error("compensation code wrong after write");
  a_short_sel: assert property (
    reg_req.wr && reg_req.addr == 8'h20
    |-> ##2 short_detect_current_sel == $past(reg_req.wdata[0], 2))
    else $error("current select wrong after write");
  a_power_gate: assert property (
    $rose(load_detect_power_on) |-> power_state == 2'h1)
    else $error("load detect powered outside Active");
endmodule

bind cldw_top cldw_top_assertions u_chk (
  .clk                      (clk),
  .reset_n                  (reset_n),
  .charger_sense_high       (charger_sense_high),
  .load_sense_low           (load_sense_low),
  .reg_req                  (reg_req),
  .reg_rdata                (reg_rdata),
  .active_state_bit         (active_state_bit),
  .load_detect_power_on     (load_detect_power_on),
  .short_detect_current_sel (short_detect_current_sel),
  .supply_comp_code         (supply_comp_code),
  .power_state              (power_state)
);

// [dv/cldw_analog_model.sv]
`timescale 1ns/10ps
module cldw_analog_model (
  // Pack conditions
  input  wire logic       plugged,
  input  wire logic [1:0] load_kind,
  // Device side
  input  wire logic       fets_off,
  input  wire logic       load_detect_power_on,
  input  wire logic       short_detect_current_sel,
  // Comparators
  output logic            charger_sense_high,
  output logic            charger_sense_low,
  output logic            load_sense_low,
  output logic            load_sense_high
);
  // Load kind 1 draws between the two bias currents, kind 2 above both
  always_comb begin
    charger_sense_high = plugged;
    charger_sense_low  = !plugged;
    load_sense_low     = fets_off && load_detect_power_on
      && (load_kind == 2'h2 || (load_kind == 2'h1 && !short_detect_current_sel));
    load_sense_high    = !load_sense_low;
  end
endmodule

// [dv/charger_load_detect_wake_tb.sv]
`timescale 1ns/10ps
module charger_load_detect_wake_tb;
  logic                clk;
  logic                reset_n;
  logic                plugged;
  logic [1:0]          load_kind;
  logic                fets_off;
  logic                sleep_req;
  logic                standby_req;
  logic                shutdown_req;
  cldw_pkg::cldw_req_t req;
  logic [15:0]         rdata;
  logic                act;
  logic                irq;
  logic                pwr_on;
  logic                short_sel;
  logic [2:0]          comp;
  logic [1:0]          ps;
  logic                c_hi;
  logic                c_lo;
  logic                l_lo;
  logic                l_hi;
  int                  n_fail;
  int                  checks_done;

  cldw_analog_model u_model (.plugged(plugged), .load_kind(load_kind),
    .fets_off(fets_off), .load_detect_power_on(pwr_on),
    .short_detect_current_sel(short_sel), .charger_sense_high(c_hi),
    .charger_sense_low(c_lo), .load_sense_low(l_lo), .load_sense_high(l_hi));

  cldw_top uut (.clk(clk), .reset_n(reset_n), .charger_sense_high(c_hi),
    .charger_sense_low(c_lo), .load_sense_low(l_lo), .load_sense_high(l_hi),
    .fets_off(fets_off), .sleep_req(sleep_req), .standby_req(standby_req),
    .shutdown_req(shutdown_req), .reg_req(req), .reg_rdata(rdata),
    .active_state_bit(act), .interrupt_output_pin(irq),
    .load_detect_power_on(pwr_on), .short_detect_current_sel(short_sel),
    .supply_comp_code(comp), .power_state(ps));

  // ********
  // Tasks
  // ********
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req = '{1'b1, 1'b0, a, d};
    cyc(1);
    req = '0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    req = '{1'b0, 1'b1, a, 16'h0000};
    cyc(1);
    req = '0;
    cyc(1);
    chk("reg_rdata", rdata, exp);
  endtask
  task automatic wait_ps(input logic [1:0] exp, input int max);
    int i;
    i = 0;
    while (ps !== exp && i < max) begin
      cyc(1);
      i++;
    end
    chk("power_state", {14'h0000, ps}, {14'h0000, exp});
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #10000000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {reset_n, plugged, fets_off, sleep_req, standby_req, shutdown_req} = '0;
    load_kind = 2'h1;
    req = '0;
    n_fail = 0;
    checks_done = 0;
    cyc(16);
    reset_n = 1'b1;
    rd(8'h01, 16'h0000);
    rd(8'h56, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(8'h1C, 16'hFFFF);
    rd(8'h1C, 16'h0000);
    wr(8'h33, 16'hFFFF);
    rd(8'h33, 16'h0000);
    $display("Test reset values done");
    wr(8'h56, 16'h000A);
    cyc(2);
    chk("supply_comp_code", {13'h0000, comp}, 16'h0005);
    wr(8'h56, 16'h000E);
    cyc(2);
    chk("supply_comp_code", {13'h0000, comp}, 16'h0000);
    rd(8'h56, 16'h000E);
    $display("Test compensation done");
    cyc(2100);
    rd(8'h27, 16'h0100);
    chk("interrupt", {15'h0000, irq}, 16'h0001);
    $display("Test plug out done");
    plugged = 1'b1;
    cyc(20000);
    plugged = 1'b0;
    cyc(3);
    plugged = 1'b1;
    cyc(490000);
    chk("power_state", {14'h0000, ps}, 16'h0000);
    wait_ps(2'h1, 10100);
    rd(8'h1C, 16'h0001);
    chk("active_state_bit", {15'h0000, act}, 16'h0001);
    rd(8'h27, 16'h4300);
    wr(8'h27, 16'h0300);
    rd(8'h27, 16'h4000);
    chk("interrupt", {15'h0000, irq}, 16'h0000);
    $display("Test startup done");
    wr(8'h20, 16'h0008);
    cyc(2);
    chk("power_on", {15'h0000, pwr_on}, 16'h0000);
    fets_off = 1'b1;
    cyc(4);
    wr(8'h20, 16'h0008);
    cyc(2);
    chk("power_on", {15'h0000, pwr_on}, 16'h0001);
    cyc(2100);
    rd(8'h27, 16'hC800);
    chk("interrupt", {15'h0000, irq}, 16'h0001);
    load_kind = 2'h0;
    cyc(2100);
    rd(8'h27, 16'h4C00);
    wr(8'h20, 16'h0009);
    load_kind = 2'h1;
    cyc(2100);
    rd(8'h27, 16'h4C00);
    load_kind = 2'h2;
    cyc(2100);
    rd(8'h27, 16'hCC00);
    wr(8'h27, 16'h0C00);
    rd(8'h27, 16'hC000);
    $display("Test load detect done");
    load_kind = 2'h0;
    wr(8'h01, 16'h0100);
    cyc(2100);
    pulse(standby_req);
    wait_ps(2'h2, 10);
    load_kind = 2'h2;
    wait_ps(2'h1, 2200);
    wr(8'h01, 16'h0200);
    plugged = 1'b0;
    cyc(2100);
    pulse(sleep_req);
    wait_ps(2'h3, 10);
    cyc(3000);
    chk("power_state", {14'h0000, ps}, 16'h0003);
    plugged = 1'b1;
    wait_ps(2'h1, 200100);
    pulse(shutdown_req);
    wait_ps(2'h0, 10);
    cyc(10);
    chk("power_state", {14'h0000, ps}, 16'h0000);
    $display("Test wake done");
    print_verdict();
  end
endmodule
